// >>> src/apr_axil_if.sv
// axi4-lite slave handshake, register access goes to the parent
`timescale 1ns/10ps
`default_nettype none
`include "apr_defines.svh"
module apr_axil_if #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address, data and response
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    if (ADDR_W < 16) begin : g_bad_addr_w
        $error("apr_axil_if: ADDR_W too small for the map");
    end
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    wire aw_hs = s_axi_awvalid & awready_reg;
    wire w_hs = s_axi_wvalid & wready_reg;
    wire ar_hs = s_axi_arvalid & arready_reg;
    // write happens once address and data are both held
    assign wr_en = ~awready_reg & ~wready_reg & ~bvalid_reg;
    assign wr_addr = awaddr_reg;
    assign wr_data = wdata_reg;
    assign wr_strb = wstrb_reg;
    assign rd_addr = s_axi_araddr;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `APR_RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (aw_hs) begin
                awready_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                wready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_en) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_err ? `APR_RESP_SLVERR : `APR_RESP_OKAY;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `APR_RESP_OKAY;
        end else if (ar_hs) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_data;
            rresp_reg <= rd_err ? `APR_RESP_SLVERR : `APR_RESP_OKAY;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule : apr_axil_if
`default_nettype wire

// >>> src/apr_defines.svh
// register map, field positions and reset values of the audio port router
`ifndef APR_DEFINES_SVH
`define APR_DEFINES_SVH
// register indices, byte address is four times the index
`define APR_IDX_ROUTE 14'h0006
`define APR_IDX_CTL2 14'h0311
`define APR_IDX_PULL_BCLK 14'h0702
`define APR_IDX_PULL_FCLK 14'h0703
`define APR_IDX_PULL_RXD 14'h0704
`define APR_IDX_ENA 14'h0800
`define APR_IDX_STAT 14'h0801
// routing control fields
`define APR_P1RX_SRC_BIT 0
`define APR_P2RX_SRC_BIT 1
`define APR_P2TX_SRC_BIT 2
`define APR_P3TX_SRC_LSB 3
`define APR_TRI_BIT 5
`define APR_P2IN_SEL_LSB 7
`define APR_MONO_SRC_LSB 9
// port two control two
`define APR_LOOP_BIT 0
// pull control
`define APR_PU_BIT 14
`define APR_PD_BIT 13
// path enable register
`define APR_LIN_EN_BIT 0
`define APR_RIN_EN_BIT 1
`define APR_LOUT_EN_BIT 2
`define APR_ROUT_EN_BIT 3
`define APR_LTX_EN_BIT 4
`define APR_RTX_EN_BIT 5
`define APR_FMT_LSB 6
// reset values
`define APR_ROUTE_RST 16'h0000
`define APR_CTL2_RST 16'h4000
`define APR_PULL_RST 16'h2000
`define APR_ENA_RST 16'h0080
// bus answers
`define APR_RESP_OKAY 2'h0
`define APR_RESP_SLVERR 2'h2
`endif

// >>> src/apr_pin_sync.sv
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module apr_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins and result
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] q
);
    if (WIDTH < 1) begin : g_bad_width
        $error("apr_pin_sync: WIDTH must be at least 1");
    end
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
        end
    endgenerate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end
    assign q = q_reg;
endmodule : apr_pin_sync
`default_nettype wire

// >>> src/apr_pkg.sv
// encodings of the audio port router selects
package apr_pkg;
    typedef enum logic [1:0] {
        APR_MONO_NONE = 2'h0,
        APR_MONO_LEFT = 2'h1,
        APR_MONO_RIGHT = 2'h2,
        APR_MONO_RSVD = 2'h3
    } apr_mono_src_t;
    typedef enum logic [1:0] {
        APR_IN_BOTH_P2 = 2'h0,
        APR_IN_RIGHT_P3 = 2'h1,
        APR_IN_LEFT_P3 = 2'h2,
        APR_IN_RSVD = 2'h3
    } apr_in_sel_t;
    typedef enum logic [1:0] {
        APR_P3TX_P1 = 2'h0,
        APR_P3TX_P2 = 2'h1,
        APR_P3TX_P2RX = 2'h2,
        APR_P3TX_MONO = 2'h3
    } apr_p3tx_src_t;
    typedef enum logic [1:0] {
        APR_FMT_RJ = 2'h0,
        APR_FMT_LJ = 2'h1,
        APR_FMT_I2S = 2'h2,
        APR_FMT_DSP = 2'h3
    } apr_fmt_t;
endpackage : apr_pkg

// >>> src/apr_top.sv
// routing, loopback and pin control of audio ports one to three
`timescale 1ns/10ps
`default_nettype none
`include "apr_defines.svh"
module apr_top #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins from the far processors
    input wire logic port_one_rx_data,
    input wire logic port_two_rx_data,
    input wire logic port_two_frame_clock,
    input wire logic port_two_bit_clock,
    input wire logic port_three_rx_data,
    // shared pin function from the pin mux
    input wire logic shared_pin_eight_audio,
    input wire logic shared_pin_nine_audio,
    // serial streams from the core
    input wire logic core_port_one_tx,
    input wire logic core_port_two_tx,
    input wire logic core_port_two_left_out,
    input wire logic core_port_two_right_out,
    // serial streams to the core and the port-three format
    output logic core_port_one_rx,
    output logic core_port_two_left_in,
    output logic core_port_two_right_in,
    output logic [1:0] port_three_format,
    // transmit pins
    output logic port_two_tx_data,
    output logic port_three_tx_data_o,
    output logic port_three_tx_data_oe,
    // pulls, index 0 bit clock, 1 frame clock, 2 receive data
    output logic [2:0] pin_pullup_en,
    output logic [2:0] pin_pulldown_en
);
    // index decode takes byte address bits 15:2
    if (ADDR_W < 16) begin : g_bad_addr_w
        $error("apr_top: ADDR_W must be at least 16");
    end
    // ==========================================================
    // register bus
    // ==========================================================
    logic wr_en, wr_err, rd_err;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    apr_axil_if #(.ADDR_W(ADDR_W)) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ==========================================================
    // address decode
    // ==========================================================
    wire [13:0] wr_idx = wr_addr[15:2];
    wire [13:0] rd_idx = rd_addr[15:2];
    // upper address bits above the map must be zero
    wire wr_aligned = (wr_addr[1:0] == 2'h0) && ((wr_addr >> 16) == '0);
    wire rd_aligned = (rd_addr[1:0] == 2'h0) && ((rd_addr >> 16) == '0);
    wire wr_route = wr_aligned && (wr_idx == `APR_IDX_ROUTE);
    wire wr_ctl2 = wr_aligned && (wr_idx == `APR_IDX_CTL2);
    wire wr_ena = wr_aligned && (wr_idx == `APR_IDX_ENA);
    wire [2:0] wr_pull;
    assign wr_pull[0] = wr_aligned && (wr_idx == `APR_IDX_PULL_BCLK);
    assign wr_pull[1] = wr_aligned && (wr_idx == `APR_IDX_PULL_FCLK);
    assign wr_pull[2] = wr_aligned && (wr_idx == `APR_IDX_PULL_RXD);
    assign wr_err = ~(wr_route | wr_ctl2 | wr_ena | (|wr_pull));
    wire [15:0] wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // ==========================================================
    // control registers
    // ==========================================================
    logic [15:0] route_reg, ctl2_reg, ena_reg;
    logic [15:0] pull_reg [3];
    wire [15:0] route_next = (route_reg & ~wmask) | (wr_data[15:0] & wmask);
    wire [15:0] ctl2_next = (ctl2_reg & ~wmask) | (wr_data[15:0] & wmask);
    wire [15:0] ena_next = (ena_reg & ~wmask) | (wr_data[15:0] & wmask);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_reg <= `APR_ROUTE_RST;
            ctl2_reg <= `APR_CTL2_RST;
            ena_reg <= `APR_ENA_RST;
        end else if (wr_en) begin
            if (wr_route) route_reg <= route_next;
            if (wr_ctl2) ctl2_reg <= ctl2_next;
            if (wr_ena) ena_reg <= ena_next;
        end
    end
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_pull
            logic pu, pd;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pull_reg[p] <= `APR_PULL_RST;
                end else if (wr_en && wr_pull[p]) begin
                    pull_reg[p] <= (pull_reg[p] & ~wmask) | (wr_data[15:0] & wmask);
                end
            end
            assign pu = pull_reg[p][`APR_PU_BIT];
            assign pd = pull_reg[p][`APR_PD_BIT];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_pullup_en[p] <= 1'b0;
                    pin_pulldown_en[p] <= 1'b1;
                end else begin
                    pin_pullup_en[p] <= pu & ~pd;
                    pin_pulldown_en[p] <= pd & ~pu;
                end
            end
        end
    endgenerate

    // ==========================================================
    // control fields
    // ==========================================================
    wire p1rx_sel = route_reg[`APR_P1RX_SRC_BIT];
    wire p2rx_sel = route_reg[`APR_P2RX_SRC_BIT];
    wire p2tx_sel = route_reg[`APR_P2TX_SRC_BIT];
    wire tri_en = route_reg[`APR_TRI_BIT];
    wire loop_en = ctl2_reg[`APR_LOOP_BIT];
    apr_pkg::apr_p3tx_src_t p3tx_sel;
    apr_pkg::apr_in_sel_t in_sel;
    apr_pkg::apr_mono_src_t mono_sel;
    apr_pkg::apr_fmt_t fmt;
    assign p3tx_sel = apr_pkg::apr_p3tx_src_t'(route_reg[`APR_P3TX_SRC_LSB +: 2]);
    assign in_sel = apr_pkg::apr_in_sel_t'(route_reg[`APR_P2IN_SEL_LSB +: 2]);
    assign mono_sel = apr_pkg::apr_mono_src_t'(route_reg[`APR_MONO_SRC_LSB +: 2]);
    assign fmt = apr_pkg::apr_fmt_t'(ena_reg[`APR_FMT_LSB +: 2]);

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [4:0] pins_sync;
    apr_pin_sync #(.WIDTH(5)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin({port_three_rx_data, port_two_bit_clock, port_two_frame_clock,
              port_two_rx_data, port_one_rx_data}),
        .q(pins_sync)
    );
    wire p1_rx_pin = pins_sync[0];
    wire p2_rx_pin = pins_sync[1];
    wire p2_fclk = pins_sync[2];
    // shared pin eight not in audio use reads as silence
    wire p3_rx_pin = pins_sync[4] & shared_pin_eight_audio;

    // ==========================================================
    // data routing
    // ==========================================================
    // left half of the frame depends on the port-three format
    wire left_phase = (fmt == apr_pkg::APR_FMT_I2S) ? ~p2_fclk : p2_fclk;
    wire p2_rx_stream = loop_en ? core_port_two_tx
                      : (p2rx_sel ? p3_rx_pin : p2_rx_pin);
    logic left_in, right_in, mono_out, p3_tx;
    always_comb begin
        unique case (in_sel)
            apr_pkg::APR_IN_BOTH_P2: begin
                left_in = p2_rx_stream;
                right_in = p2_rx_stream;
            end
            apr_pkg::APR_IN_RIGHT_P3: begin
                left_in = p2_rx_stream;
                right_in = p3_rx_pin;
            end
            apr_pkg::APR_IN_LEFT_P3: begin
                left_in = p3_rx_pin;
                right_in = p2_rx_stream;
            end
            apr_pkg::APR_IN_RSVD: begin
                left_in = 1'b0;
                right_in = 1'b0;
            end
        endcase
    end
    always_comb begin
        unique case (mono_sel)
            apr_pkg::APR_MONO_NONE: mono_out = 1'b0;
            apr_pkg::APR_MONO_LEFT: mono_out = core_port_two_left_out;
            apr_pkg::APR_MONO_RIGHT: mono_out = core_port_two_right_out;
            apr_pkg::APR_MONO_RSVD: mono_out = 1'b0;
        endcase
    end
    always_comb begin
        unique case (p3tx_sel)
            apr_pkg::APR_P3TX_P1: p3_tx = core_port_one_tx;
            apr_pkg::APR_P3TX_P2: p3_tx = core_port_two_tx;
            apr_pkg::APR_P3TX_P2RX: p3_tx = p2_rx_pin;
            apr_pkg::APR_P3TX_MONO: p3_tx = mono_out;
        endcase
    end
    // transmit gated per channel half
    wire tx_on = left_phase ? ena_reg[`APR_LTX_EN_BIT] : ena_reg[`APR_RTX_EN_BIT];
    wire p2_tx_next = p2tx_sel ? p3_rx_pin
                    : (core_port_two_tx & tx_on);
    wire p3_drive = shared_pin_nine_audio & ~tri_en;

    // ==========================================================
    // output registers
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_port_one_rx <= 1'b0;
            core_port_two_left_in <= 1'b0;
            core_port_two_right_in <= 1'b0;
            port_two_tx_data <= 1'b0;
            port_three_tx_data_o <= 1'b0;
            port_three_tx_data_oe <= 1'b0;
            port_three_format <= 2'h2;
        end else begin
            core_port_one_rx <= p1rx_sel ? p3_rx_pin : p1_rx_pin;
            core_port_two_left_in <= left_in & ena_reg[`APR_LIN_EN_BIT];
            core_port_two_right_in <= right_in & ena_reg[`APR_RIN_EN_BIT];
            port_two_tx_data <= p2_tx_next;
            port_three_tx_data_o <= p3_tx & p3_drive;
            port_three_tx_data_oe <= p3_drive;
            port_three_format <= fmt;
        end
    end

    // ==========================================================
    // read decode
    // ==========================================================
    wire [15:0] stat = {10'h000, port_three_tx_data_oe, pins_sync};
    logic [15:0] rd_val;
    logic rd_hit;
    always_comb begin
        rd_val = 16'h0000;
        rd_hit = rd_aligned;
        unique case (rd_idx)
            `APR_IDX_ROUTE: rd_val = route_reg;
            `APR_IDX_CTL2: rd_val = ctl2_reg;
            `APR_IDX_PULL_BCLK: rd_val = pull_reg[0];
            `APR_IDX_PULL_FCLK: rd_val = pull_reg[1];
            `APR_IDX_PULL_RXD: rd_val = pull_reg[2];
            `APR_IDX_ENA: rd_val = ena_reg;
            `APR_IDX_STAT: rd_val = stat;
            default: rd_hit = 1'b0;
        endcase
        if (!rd_hit) begin
            rd_val = 16'h0000;
        end
    end
    assign rd_data = {16'h0000, rd_val};
    assign rd_err = ~rd_hit;
endmodule : apr_top
`default_nettype wire

// >>> verif/apr_chk.sv
// assertions on the audio port router ports
`timescale 1ns/10ps
`default_nettype none
module apr_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pins
    input wire logic shared_pin_nine_audio,
    input wire logic port_three_tx_data_oe,
    input wire logic [2:0] pin_pullup_en,
    input wire logic [2:0] pin_pulldown_en
);
    // ==========
    // properties
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    a_pull_exclusive: assert property ((pin_pullup_en & pin_pulldown_en) == 3'h0)
        else $error("pull-up and pull-down both applied");
    a_pull_reset: assert property ($rose(aresetn) |-> pin_pulldown_en == 3'h7)
        else $error("pull-down not on after reset");
    a_oe_needs_pin: assert property (port_three_tx_data_oe |-> $past(shared_pin_nine_audio))
        else $error("port three pin driven while not audio");
    a_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_write_stall: assert property (s_wr_both |=> !s_axi_awready && !s_axi_wready)
        else $error("write readies not dropped");
    a_bresp_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data changed while waiting");
endmodule : apr_chk
bind apr_top apr_chk chk_u (.*);
`default_nettype wire

// >>> verif/apr_far_end.sv
// far processors driving the serial pins of ports one to three
`timescale 1ns/10ps
`default_nettype none
module apr_far_end (
    // levels from the bench
    input wire logic frame_on,
    input wire logic frame_lvl,
    input wire logic [2:0] data_lvl,
    // pins
    output logic port_one_rx_data,
    output logic port_two_rx_data,
    output logic port_two_frame_clock,
    output var logic port_two_bit_clock,
    output logic port_three_rx_data
);
    // ==========
    // link clock, 800 ns, still between frames
    initial port_two_bit_clock = 1'b0;
    always #400 port_two_bit_clock = frame_on ? ~port_two_bit_clock : 1'b0;
    assign port_two_frame_clock = frame_lvl;
    assign {port_three_rx_data, port_two_rx_data, port_one_rx_data} = data_lvl;
endmodule : apr_far_end
`default_nettype wire

// >>> verif/apr_top_test.sv
// self-checking bench of the audio port router
`timescale 1ns/10ps
`default_nettype none
module apr_top_test;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic [1:0] s_axi_bresp, s_axi_rresp, port_three_format, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic port_one_rx_data, port_two_rx_data, port_two_frame_clock, port_two_bit_clock;
    logic port_three_rx_data, core_port_one_rx, core_port_two_left_in, core_port_two_right_in;
    logic port_two_tx_data, port_three_tx_data_o, port_three_tx_data_oe;
    logic shared_pin_eight_audio = 1'b1, shared_pin_nine_audio = 1'b1;
    logic core_port_one_tx = 1'b0, core_port_two_tx = 1'b0;
    logic core_port_two_left_out = 1'b0, core_port_two_right_out = 1'b0;
    logic [2:0] pin_pullup_en, pin_pulldown_en, data_lvl = 3'h0;
    logic frame_on = 1'b0, frame_lvl = 1'b0;
    logic [10:0] rt;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    apr_top #(.ADDR_W(16)) dut_u (.*);
    apr_far_end far_u (.*);
    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ==========
    // bus tasks
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd
    task automatic settle();
        repeat (6) @(posedge aclk);
    endtask : settle
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("mismatches %0d, checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // ==========
    // expected routing, d = {p3, p2, p1}, c = {right, left, p2 tx, p1 tx}
    function automatic logic [5:0] exp_all(input logic [10:0] r, input logic [2:0] d,
            input logic [3:0] c);
        logic s2, mono, p3o;
        logic [1:0] lr;
        s2 = r[1] ? d[2] : d[1];
        mono = r[10:9] == 2'h1 ? c[2] : (r[10:9] == 2'h2 ? c[3] : 1'b0);
        lr = r[8:7] == 2'h0 ? {s2, s2} : r[8:7] == 2'h1 ? {s2, d[2]} :
            r[8:7] == 2'h2 ? {d[2], s2} : 2'h0;
        p3o = r[4:3] == 2'h0 ? c[0] : r[4:3] == 2'h1 ? c[1] : r[4:3] == 2'h2 ? d[1] : mono;
        return {r[0] ? d[2] : d[0], lr, r[2] ? d[2] : c[1], p3o, 1'b1};
    endfunction : exp_all
    // ==========
    // main sequence
    initial begin
        void'($urandom(34797));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(16'h1c08, rdv);
        chk(rdv, 32'h2000);
        rd(16'h0100, rdv);
        chk({rdv[29:0], resp}, 32'h2);
        wr(16'h2000, 32'hb3);
        frame_on <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            rt = 11'($urandom) & 11'h79f;
            if (i == 0) rt = 11'h79f;
            if (rt[4:3] == 2'h1) rt[2] = 1'b0;
            data_lvl <= 3'($urandom);
            {core_port_two_right_out, core_port_two_left_out, core_port_two_tx,
                core_port_one_tx} <= 4'($urandom);
            wr(16'h0018, {21'h0, rt});
            settle();
            chk(32'({core_port_one_rx, core_port_two_left_in, core_port_two_right_in,
                port_two_tx_data, port_three_tx_data_o, port_three_tx_data_oe}),
                32'(exp_all(rt, data_lvl, {core_port_two_right_out, core_port_two_left_out,
                core_port_two_tx, core_port_one_tx})));
            chk(32'(port_three_format), 32'h2);
            rd(16'h2004, rdv);
            chk(32'({rdv[5:4], rdv[2:0]}), 32'({1'b1, data_lvl[2], 1'b0, data_lvl[1:0]}));
        end
        frame_on <= 1'b0;
        wr(16'h0018, 32'h0);
        wr(16'h0c44, 32'h4001);
        core_port_two_tx <= 1'b1;
        data_lvl <= 3'h0;
        settle();
        chk(32'({core_port_two_left_in, core_port_two_right_in}), 32'h3);
        wr(16'h0c44, 32'h4000);
        wr(16'h2000, 32'hc0);
        settle();
        chk(32'({port_three_format, port_two_tx_data}), 32'h6);
        wr(16'h0018, 32'h38);
        settle();
        chk(32'({port_three_tx_data_oe, port_three_tx_data_o}), 32'h0);
        wr(16'h0018, 32'h18);
        shared_pin_nine_audio <= 1'b0;
        settle();
        chk(32'(port_three_tx_data_oe), 32'h0);
        for (int k = 0; k < 3; k++)
            for (int v = 0; v < 4; v++) begin
                wr(16'h1c08 + 16'(k * 4), 32'(v) << 13);
                settle();
                chk(32'({pin_pullup_en[k], pin_pulldown_en[k]}),
                    32'(v == 1 ? 1 : (v == 2 ? 2 : 0)));
            end
        tally_and_finish();
    end
endmodule : apr_top_test
`default_nettype wire
